//--- shared/tmc_pkg.sv
// package for the trigger model command controller
// assumes a 40 MHz aclk and an AXI4-Lite master with 32-bit data
package tmc_pkg;

	// ==========================================================
	// bus structs
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tmc_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} tmc_axil_rsp_t;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_TIMER = 8'h08;
	localparam logic [7:0] OFF_DELAY = 8'h0c;
	localparam logic [7:0] OFF_TCOUNT = 8'h10;
	localparam logic [7:0] OFF_SCOUNT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_ERROR = 8'h1c;
	localparam logic [7:0] OFF_RESULT = 8'h20;
	localparam logic [7:0] OFF_BUFSEL = 8'h24;
	localparam logic [7:0] OFF_BUFDATA = 8'h28;

	// ==========================================================
	// field positions
	localparam int unsigned CMD_ABORT = 0;
	localparam int unsigned CMD_INIT = 1;
	localparam int unsigned CMD_FETCH = 2;
	localparam int unsigned CMD_READ = 3;
	localparam int unsigned CMD_SIGNAL = 4;
	localparam int unsigned CMD_PRESET = 5;
	localparam int unsigned CMD_RESET = 6;
	localparam int unsigned CMD_BUSTRG = 7;

	localparam int unsigned CTL_CONT = 0;
	localparam int unsigned CTL_SRC_LSB = 1;
	localparam int unsigned CTL_AUTO = 4;
	localparam int unsigned CTL_HOLD = 5;
	localparam int unsigned CTL_BEEP = 6;
	localparam int unsigned CTL_INF = 7;
	localparam int unsigned CTL_SCAN = 8;

	localparam int unsigned ST_RUN = 3;
	localparam int unsigned ST_WAITSRC = 4;
	localparam int unsigned ST_RESVALID = 5;
	localparam int unsigned ST_READPEND = 6;
	localparam int unsigned ST_ERRFLAG = 7;

	// ==========================================================
	// modes and states
	typedef enum logic [2:0] {SRC_IMM, SRC_TIM, SRC_MAN, SRC_BUS, SRC_EXT} tmc_src_t;
	typedef enum logic [2:0] {ST_IDLE, ST_TOP, ST_SRC, ST_DELAY, ST_MEAS} tmc_state_t;

	// ==========================================================
	// defaults, limits, error codes
	localparam logic [29:0] TIMER_DEF_MS = 30'h0000064;
	localparam logic [29:0] DELAY_DEF_MS = 30'h0000000;
	localparam logic [31:0] TIME_MAX_MS = 32'h3b9ac9ff;
	localparam logic [15:0] COUNT_MIN = 16'h0001;
	localparam logic [15:0] COUNT_MAX = 16'hd6d8;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_SIGNAL = 16'hff2d;
	localparam logic [15:0] ERR_INIT = 16'hff2b;
	localparam logic [15:0] ERR_CONFLICT = 16'hff23;
	localparam logic [15:0] ERR_RANGE = 16'hff22;

	// ==========================================================
	// timing and buffer
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_NS;
	localparam int unsigned BUF_AW = 4;
	localparam int unsigned BUF_DEPTH = 16;

endpackage : tmc_pkg

//--- verification/tmc_meas_model.sv
// measurement core stand-in, one reading per start
// assumes starts arrive on aclk; data toggles outside a reading
`timescale 1ns/1ps
module tmc_meas_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic meas_start,
	output logic meas_done,
	output logic [31:0] meas_data
);
	int wait_cnt;
	int n;
	always_ff @(posedge aclk) begin
		meas_done <= 1'b0;
		meas_data <= ~meas_data;
		if (!aresetn) begin
			wait_cnt <= 0;
			n <= 0;
			meas_data <= 32'h0;
		end else if (meas_start) begin
			wait_cnt <= slow ? 9 : 1;
		end else if (wait_cnt == 1) begin
			meas_done <= 1'b1;
			meas_data <= {16'ha5a5, n[15:0]};
			n <= n + 1;
			wait_cnt <= 0;
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : tmc_meas_model

//--- verification/tmc_trigger_ctrl_assertions.sv
// checker for the trigger controller ports
// assumes a bind from the bench top and the single aclk domain
`timescale 1ns/1ps
module tmc_trigger_ctrl_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire tmc_pkg::tmc_axil_req_t axi_req,
	input wire tmc_pkg::tmc_axil_rsp_t axi_rsp,
	input wire logic manual_trig,
	input wire logic ext_trig_in,
	input wire logic meas_done,
	input wire logic [31:0] meas_data,
	input wire logic meas_start,
	input wire logic ext_trig_out,
	input wire logic hold_en,
	input wire logic beeper_en,
	input wire logic internal_scanner_select
);
	import tmc_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// helpers
	logic wr, cmd_wr, ctl_wr, ok_ctl, cont;
	assign wr = axi_req.awvalid && axi_req.wvalid && axi_rsp.awready;
	assign cmd_wr = wr && axi_req.awaddr == OFF_CMD;
	assign ctl_wr = wr && axi_req.awaddr == OFF_CTRL && axi_req.wstrb == 4'hf;
	assign ok_ctl = ctl_wr && (!internal_scanner_select || axi_req.wdata[CTL_HOLD] == hold_en);
	always_ff @(posedge aclk) begin
		if (!aresetn) cont <= 1'b0;
		else if (ctl_wr) cont <= axi_req.wdata[CTL_CONT];
		else if (cmd_wr && axi_req.wdata[CMD_RESET]) cont <= 1'b0;
		else if (cmd_wr && axi_req.wdata[CMD_PRESET]) cont <= 1'b1;
	end
	// ==========================================================
	// properties
	property p_rst_dflt;
		$rose(aresetn) |-> beeper_en && !hold_en && !internal_scanner_select;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");
	property p_abort_idle;
		cmd_wr && axi_req.wdata[7:0] == 8'h01 && !cont |-> ##2 !meas_start [*8];
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("measure after abort");
	property p_rst_cmd;
		cmd_wr && axi_req.wdata[7:0] == 8'h40 |=> beeper_en && !hold_en ##1 !meas_start [*8];
	endproperty
	a_rst_cmd: assert property (p_rst_cmd) else $error("reset command wrong");
	property p_hold;
		ok_ctl |=> hold_en == $past(axi_req.wdata[CTL_HOLD]);
	endproperty
	a_hold: assert property (p_hold) else $error("hold not written");
	property p_hold_conf;
		ctl_wr && internal_scanner_select && axi_req.wdata[CTL_HOLD] != hold_en |=> $stable(hold_en);
	endproperty
	a_hold_conf: assert property (p_hold_conf) else $error("hold changed with scanner");
	property p_beep;
		ok_ctl |=> beeper_en == $past(axi_req.wdata[CTL_BEEP])
			&& internal_scanner_select == $past(axi_req.wdata[CTL_SCAN]);
	endproperty
	a_beep: assert property (p_beep) else $error("beeper or scanner not written");
	property p_trig_out;
		ext_trig_out |-> $past(meas_done);
	endproperty
	a_trig_out: assert property (p_trig_out) else $error("output trigger without reading");
	property p_start;
		meas_start |=> !meas_start [*2];
	endproperty
	a_start: assert property (p_start) else $error("start repeated");
	c_meas: cover property (meas_start);
	c_trig: cover property (ext_trig_out);
	c_conf: cover property (ctl_wr && internal_scanner_select && axi_req.wdata[CTL_HOLD] != hold_en);
endmodule : tmc_trigger_ctrl_assertions

//--- verification/tmc_trigger_ctrl_test.sv
// self-checking bench for the trigger controller
// assumes package, design, checker and measurement model compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tmc_trigger_ctrl_test;
	import tmc_pkg::*;
	logic aclk, aresetn, manual_trig, ext_trig_in, meas_done, meas_start, ext_trig_out, slow;
	logic hold_en, beeper_en, internal_scanner_select, rr_ok;
	logic [31:0] meas_data, rv;
	logic [1:0] rr;
	tmc_axil_req_t axi_req;
	tmc_axil_rsp_t axi_rsp;
	int mismatches, tests_run, n_meas, n_trig, n_done, cyc, t_prev, t_last, m0, g0, tc, sc;
	logic [7:0] ofs[6] = '{OFF_CTRL, OFF_TIMER, OFF_DELAY, OFF_TCOUNT, OFF_SCOUNT, OFF_STATUS};
	logic [31:0] dfl[6] = '{32'h40, {2'h0, TIMER_DEF_MS}, 32'h0, 32'h1, 32'h1, 32'h0};
	tmc_trigger_ctrl #(.MS_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .manual_trig(manual_trig), .ext_trig_in(ext_trig_in),
		.meas_done(meas_done), .meas_data(meas_data), .meas_start(meas_start),
		.ext_trig_out(ext_trig_out), .hold_en(hold_en), .beeper_en(beeper_en),
		.internal_scanner_select(internal_scanner_select));
	tmc_meas_model u_core (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.meas_start(meas_start), .meas_done(meas_done), .meas_data(meas_data));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		n_trig += ext_trig_out;
		n_done += meas_done;
		if (meas_start) begin
			n_meas++;
			t_prev = t_last;
			t_last = cyc;
		end
	end
	// ==========================================================
	// helpers
	function automatic logic [31:0] exp_rd(input int k);
		return {16'ha5a5, k[15:0]};
	endfunction : exp_rd
	task automatic pass(input int k, output logic got);
		@(negedge aclk);
		got = k == 0 ? axi_rsp.awready : k == 1 ? axi_rsp.bvalid : k == 2 ? axi_rsp.arready
			: axi_rsp.rvalid;
		@(posedge aclk);
	endtask : pass
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic got;
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		do pass(0, got); while (!got);
		axi_req.awvalid <= 1'b0;
		axi_req.wvalid <= 1'b0;
		do pass(1, got); while (!got);
		axi_req.bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic got;
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do pass(2, got); while (!got);
		axi_req.arvalid <= 1'b0;
		do pass(3, got); while (!got);
		rv = axi_rsp.rdata;
		rr = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a);
		`CHK(nm, e, rv)
	endtask : chk_rd
	task automatic chk_err(input logic [15:0] e);
		rd(OFF_ERROR);
		`CHK("error code", e, rv[15:0])
		wr(OFF_ERROR, 32'h0);
	endtask : chk_err
	task automatic wait_idle();
		do rd(OFF_STATUS); while (rv[ST_RUN] !== 1'b0);
	endtask : wait_idle
	task automatic ev(input int s);
		do rd(OFF_STATUS); while (rv[ST_WAITSRC] !== 1'b1);
		if (s == 2) manual_trig <= 1'b1;
		if (s == 4) ext_trig_in <= 1'b1;
		if (s == 3) wr(OFF_CMD, 32'h80);
		if (s == 5) wr(OFF_CMD, 32'h10);
		@(posedge aclk);
		manual_trig <= 1'b0;
		ext_trig_in <= 1'b0;
	endtask : ev
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	// ==========================================================
	// watchdog, generous against about 1200 expected cycles
	initial begin
		repeat (60000) @(posedge aclk);
		mismatches++;
		end_of_test();
	end
	// ==========================================================
	// tests
	initial begin
		axi_req = '0;
		aresetn = 1'b0;
		manual_trig = 1'b0;
		ext_trig_in = 1'b0;
		slow = 1'b0;
		void'($urandom(32'h1423));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (ofs[i]) chk_rd(ofs[i], dfl[i], "default");
		rd(8'h2c);
		`CHK("unmapped", RESP_SLVERR, rr)
		wr(OFF_TIMER, TIME_MAX_MS + 32'h1);
		chk_err(ERR_RANGE);
		wr(OFF_TCOUNT, 32'h0);
		chk_err(ERR_RANGE);
		$display("test defaults done");
		for (int it = 0; it < 4; it++) begin
			tc = 1 + $urandom % 3;
			sc = it == 3 ? 17 : 1 + $urandom % 3;
			slow <= $urandom % 2;
			wr(OFF_TCOUNT, tc);
			wr(OFF_SCOUNT, sc);
			m0 = n_meas;
			g0 = n_trig;
			wr(OFF_CMD, 32'h2);
			wait_idle();
			`CHK("measures", tc * sc, n_meas - m0)
			`CHK("link out", tc, n_trig - g0)
			for (int j = 0; j < 16 && j < sc && sc > 1; j++) begin
				wr(OFF_BUFSEL, j);
				chk_rd(OFF_BUFDATA, exp_rd(n_done - sc + (j + 16 < sc ? j + 16 : j)), "buf");
			end
		end
		$display("test counts done");
		wr(OFF_TCOUNT, 32'h1);
		wr(OFF_SCOUNT, 32'h1);
		m0 = n_meas;
		wr(OFF_CMD, 32'h8);
		wait_idle();
		chk_rd(OFF_RESULT, exp_rd(n_done - 1), "read result");
		wr(OFF_CMD, 32'h4);
		repeat (20) @(posedge aclk);
		chk_rd(OFF_RESULT, exp_rd(n_done - 1), "fetch result");
		`CHK("read and fetch", m0 + 1, n_meas)
		$display("test read fetch done");
		for (int s = 2; s < 6; s++) begin
			wr(OFF_CTRL, 32'h40 | ((s == 5 ? 2 : s) << CTL_SRC_LSB));
			m0 = n_meas;
			wr(OFF_CMD, 32'h2);
			if (s == 5) wr(OFF_CMD, 32'h2);
			if (s == 5) chk_err(ERR_INIT);
			ev(s);
			wait_idle();
			`CHK("source event", 1, n_meas - m0)
		end
		wr(OFF_CMD, 32'h10);
		chk_err(ERR_SIGNAL);
		$display("test sources done");
		wr(OFF_CTRL, 32'h52);
		wr(OFF_TIMER, 32'h5);
		wr(OFF_DELAY, 32'h1);
		wr(OFF_TCOUNT, 32'h2);
		m0 = cyc;
		wr(OFF_CMD, 32'h2);
		wait_idle();
		`CHK("timer bypass", 1'b1, t_prev - m0 < 20)
		`CHK("timer wait", 1'b1, t_last - t_prev >= 20)
		wr(OFF_CTRL, 32'h40);
		chk_rd(OFF_DELAY, 32'h0, "auto off delay");
		$display("test timer done");
		wr(OFF_CTRL, 32'h41);
		wr(OFF_SCOUNT, 32'h2);
		chk_err(ERR_CONFLICT);
		chk_rd(OFF_SCOUNT, 32'h1, "samples kept");
		wr(OFF_CMD, 32'h8);
		chk_err(ERR_CONFLICT);
		wr(OFF_CMD, 32'h1);
		m0 = n_meas;
		repeat (40) @(posedge aclk);
		`CHK("abort continues", 1'b1, n_meas > m0)
		wr(OFF_CMD, 32'h40);
		chk_rd(OFF_CTRL, 32'h40, "ctrl after reset");
		chk_rd(OFF_TCOUNT, 32'h1, "count after reset");
		m0 = n_meas;
		repeat (40) @(posedge aclk);
		`CHK("reset idles", m0, n_meas)
		wr(OFF_CMD, 32'h20);
		rd(OFF_CTRL);
		`CHK("preset bits", 2'h3, {rv[CTL_INF], rv[CTL_CONT]})
		m0 = n_meas;
		repeat (60) @(posedge aclk);
		`CHK("infinite loops", 1'b1, n_meas > m0 + 2)
		wr(OFF_CTRL, 32'hc0);
		wr(OFF_CMD, 32'h1);
		m0 = n_meas;
		repeat (40) @(posedge aclk);
		`CHK("abort idles", m0, n_meas)
		rd(OFF_STATUS);
		`CHK("idle state", 4'h0, rv[3:0])
		$display("test continuous done");
		wr(OFF_CTRL, 32'h60);
		wr(OFF_CTRL, 32'h160);
		wr(OFF_CTRL, 32'h140);
		chk_err(ERR_CONFLICT);
		`CHK("hold kept", 1'b1, hold_en)
		wr(OFF_CMD, 32'h40);
		`CHK("hold off", 1'b0, hold_en)
		$display("test hold done");
		end_of_test();
	end
endmodule : tmc_trigger_ctrl_test
bind tmc_trigger_ctrl tmc_trigger_ctrl_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .manual_trig(manual_trig), .ext_trig_in(ext_trig_in),
	.meas_done(meas_done), .meas_data(meas_data), .meas_start(meas_start),
	.ext_trig_out(ext_trig_out), .hold_en(hold_en), .beeper_en(beeper_en),
	.internal_scanner_select(internal_scanner_select));

//--- verilog/tmc_trigger_ctrl.sv
// trigger sequencer with command register file on AXI4-Lite
// assumes a measurement core answering meas_start with a meas_done pulse,
// and trigger link pins already synchronous to aclk
`timescale 1ns/1ps

// Operation
// - abort with continuous off returns to idle
// - abort with continuous on restarts at top
// - initiate from idle runs exactly one pass
// - initiate while running flags error, ignored
// - continuous on rejects read and samples above one
// - fetch returns last reading, no new cycle
// - read acts as abort, initiate, then fetch
// - source immediate, timer, manual, bus, external
// - timer interval zero to max, default 0.1s
// - trigger count 1 to 55000 or infinite
// - preset sets infinite count and continuous on
// - reset restores defaults, count one, idle
// - delay zero to max, default zero
// - control write with auto delay off sets delay zero
// - signal satisfies pending source event immediately
// - signal outside source wait errors, ignored
// - sample count 1 to 55000, default 1
// - multiple samples stored into reading buffer
// - hold switchable, default off
// - hold change with scanner on gives conflict
// - beeper switchable, default on
// - timer bypassed first pass, then longer wait
// - external source satisfied by link pulse
// - bus source satisfied by bus trigger
// - output trigger after each sample series
module tmc_trigger_ctrl #(
	parameter int unsigned MS_CYCLES = tmc_pkg::MS_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire tmc_pkg::tmc_axil_req_t axi_req,
	output tmc_pkg::tmc_axil_rsp_t axi_rsp,
	input wire logic manual_trig,
	input wire logic ext_trig_in,
	input wire logic meas_done,
	input wire logic [31:0] meas_data,
	output logic meas_start,
	output logic ext_trig_out,
	output logic hold_en,
	output logic beeper_en,
	output logic internal_scanner_select
);
	import tmc_pkg::*;

	// ==========================================================
	// state
	tmc_state_t state;
	tmc_src_t src;
	logic cont_on;
	logic auto_delay;
	logic trig_inf;
	logic [29:0] timer_ms;
	logic [29:0] delay_ms;
	logic [15:0] trig_count;
	logic [15:0] samp_count;
	logic [15:0] trig_left;
	logic [15:0] samp_left;
	logic first_pass;
	logic [29:0] wait_ms;
	logic [29:0] ms_cnt;
	logic [15:0] presc;
	logic [15:0] err_code;
	logic [31:0] last_reading;
	logic have_reading;
	logic [31:0] result;
	logic result_valid;
	logic read_pending;
	logic [BUF_AW-1:0] buf_sel;
	logic [31:0] buf_mem [BUF_DEPTH];
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;

	// ==========================================================
	// helpers
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction : wmerge

	function automatic logic [32:0] reg_view(input logic [7:0] addr);
		logic [32:0] v;
		v = {1'b1, 32'h00000000};
		if (addr == OFF_CMD) begin
			v[31:0] = 32'h00000000;
		end else if (addr == OFF_CTRL) begin
			v[CTL_CONT] = cont_on;
			v[CTL_SRC_LSB +: 3] = src;
			v[CTL_AUTO] = auto_delay;
			v[CTL_HOLD] = hold_en;
			v[CTL_BEEP] = beeper_en;
			v[CTL_INF] = trig_inf;
			v[CTL_SCAN] = internal_scanner_select;
		end else if (addr == OFF_TIMER) begin
			v[29:0] = timer_ms;
		end else if (addr == OFF_DELAY) begin
			v[29:0] = delay_ms;
		end else if (addr == OFF_TCOUNT) begin
			v[15:0] = trig_count;
		end else if (addr == OFF_SCOUNT) begin
			v[15:0] = samp_count;
		end else if (addr == OFF_STATUS) begin
			v[2:0] = state;
			v[ST_RUN] = (state != ST_IDLE);
			v[ST_WAITSRC] = (state == ST_SRC);
			v[ST_RESVALID] = result_valid;
			v[ST_READPEND] = read_pending;
			v[ST_ERRFLAG] = (err_code != ERR_NONE);
		end else if (addr == OFF_ERROR) begin
			v[15:0] = err_code;
		end else if (addr == OFF_RESULT) begin
			v[31:0] = result;
		end else if (addr == OFF_BUFSEL) begin
			v[BUF_AW-1:0] = buf_sel;
		end else if (addr == OFF_BUFDATA) begin
			v[31:0] = buf_mem[buf_sel];
		end else begin
			v[32] = 1'b0;
		end
		return v;
	endfunction : reg_view

	// ==========================================================
	// write decode
	logic wr_fire;
	logic [32:0] wr_view;
	logic [31:0] wd;
	logic wr_ctrl;
	logic wr_cmd;
	logic cmd_abort;
	logic cmd_init;
	logic cmd_fetch;
	logic cmd_read;
	logic cmd_signal;
	logic cmd_preset;
	logic cmd_reset;
	logic cmd_bustrg;
	logic read_go;
	logic seq_kill;
	logic rej_init;
	logic rej_signal;
	logic rej_read;
	logic rej_hold;
	logic rej_src;
	logic rej_timer;
	logic rej_delay;
	logic rej_tcount;
	logic rej_scount;
	logic [15:0] next_err;

	assign wr_fire = axi_req.awvalid && axi_req.wvalid && !bvalid;
	always_comb wr_view = reg_view(axi_req.awaddr);
	assign wd = wmerge(wr_view[31:0], axi_req.wdata, axi_req.wstrb);
	assign wr_cmd = wr_fire && (axi_req.awaddr == OFF_CMD);
	assign wr_ctrl = wr_fire && (axi_req.awaddr == OFF_CTRL);
	assign cmd_abort = wr_cmd && wd[CMD_ABORT];
	assign cmd_init = wr_cmd && wd[CMD_INIT];
	assign cmd_fetch = wr_cmd && wd[CMD_FETCH];
	assign cmd_read = wr_cmd && wd[CMD_READ];
	assign cmd_signal = wr_cmd && wd[CMD_SIGNAL];
	assign cmd_preset = wr_cmd && wd[CMD_PRESET];
	assign cmd_reset = wr_cmd && wd[CMD_RESET];
	assign cmd_bustrg = wr_cmd && wd[CMD_BUSTRG];

	assign rej_read = cmd_read && cont_on;
	assign read_go = cmd_read && !cont_on;
	assign seq_kill = cmd_reset || cmd_preset || cmd_abort || read_go;
	assign rej_init = cmd_init && !seq_kill && (state != ST_IDLE);
	assign rej_signal = cmd_signal && (state != ST_SRC);
	assign rej_hold = wr_ctrl && internal_scanner_select && (wd[CTL_HOLD] != hold_en);
	assign rej_src = wr_ctrl && (wd[CTL_SRC_LSB +: 3] > SRC_EXT);
	assign rej_timer = wr_fire && (axi_req.awaddr == OFF_TIMER) && (wd > TIME_MAX_MS);
	assign rej_delay = wr_fire && (axi_req.awaddr == OFF_DELAY) && (wd > TIME_MAX_MS);
	assign rej_tcount = wr_fire && (axi_req.awaddr == OFF_TCOUNT)
		&& ((wd < 32'(COUNT_MIN)) || (wd > 32'(COUNT_MAX)));
	assign rej_scount = wr_fire && (axi_req.awaddr == OFF_SCOUNT)
		&& ((wd < 32'(COUNT_MIN)) || (wd > 32'(COUNT_MAX))
		|| (cont_on && (wd > 32'(COUNT_MIN))));

	always_comb begin
		next_err = ERR_NONE;
		if (rej_hold || rej_read || (rej_scount && cont_on)) begin
			next_err = ERR_CONFLICT;
		end else if (rej_init) begin
			next_err = ERR_INIT;
		end else if (rej_signal) begin
			next_err = ERR_SIGNAL;
		end else if (rej_src || rej_timer || rej_delay || rej_tcount || rej_scount) begin
			next_err = ERR_RANGE;
		end
	end

	// ==========================================================
	// settings
	always_ff @(posedge aclk) begin
		if (!aresetn || cmd_reset) begin
			cont_on <= 1'b0;
			trig_inf <= 1'b0;
			trig_count <= COUNT_MIN;
			src <= SRC_IMM;
			timer_ms <= TIMER_DEF_MS;
			delay_ms <= DELAY_DEF_MS;
			samp_count <= COUNT_MIN;
			auto_delay <= 1'b0;
			hold_en <= 1'b0;
			beeper_en <= 1'b1;
			internal_scanner_select <= 1'b0;
		end else if (cmd_preset) begin
			trig_inf <= 1'b1;
			cont_on <= 1'b1;
		end else if (wr_ctrl) begin
			cont_on <= wd[CTL_CONT];
			if (!rej_src) begin
				src <= tmc_src_t'(wd[CTL_SRC_LSB +: 3]);
			end
			auto_delay <= wd[CTL_AUTO];
			if (!wd[CTL_AUTO]) begin
				delay_ms <= DELAY_DEF_MS;
			end
			if (!rej_hold) begin
				hold_en <= wd[CTL_HOLD];
			end
			beeper_en <= wd[CTL_BEEP];
			trig_inf <= wd[CTL_INF];
			internal_scanner_select <= wd[CTL_SCAN];
		end else if (wr_fire && (axi_req.awaddr == OFF_TIMER) && !rej_timer) begin
			timer_ms <= wd[29:0];
		end else if (wr_fire && (axi_req.awaddr == OFF_DELAY) && !rej_delay) begin
			delay_ms <= wd[29:0];
		end else if (wr_fire && (axi_req.awaddr == OFF_TCOUNT) && !rej_tcount) begin
			trig_count <= wd[15:0];
		end else if (wr_fire && (axi_req.awaddr == OFF_SCOUNT) && !rej_scount) begin
			samp_count <= wd[15:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_sel <= '0;
		end else if (wr_fire && (axi_req.awaddr == OFF_BUFSEL)) begin
			buf_sel <= wd[BUF_AW-1:0];
		end
	end

	// ==========================================================
	// error code, new error wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_code <= ERR_NONE;
		end else if (next_err != ERR_NONE) begin
			err_code <= next_err;
		end else if (wr_fire && (axi_req.awaddr == OFF_ERROR)) begin
			err_code <= ERR_NONE;
		end
	end

	// ==========================================================
	// sequencer
	logic src_ok;
	logic delay_done;
	logic meas_fire;
	logic last_sample;
	logic last_trig;

	always_comb begin
		src_ok = cmd_signal;
		case (src)
			SRC_IMM: src_ok = 1'b1;
			SRC_TIM: src_ok = 1'b1;
			SRC_MAN: src_ok = src_ok || manual_trig;
			SRC_BUS: src_ok = src_ok || cmd_bustrg;
			SRC_EXT: src_ok = src_ok || ext_trig_in;
			default: src_ok = cmd_signal;
		endcase
	end

	assign delay_done = (ms_cnt >= wait_ms);
	assign meas_fire = (state == ST_MEAS) && meas_done && !seq_kill;
	assign last_sample = (samp_left <= COUNT_MIN);
	assign last_trig = !trig_inf && (trig_left <= COUNT_MIN);

	always_ff @(posedge aclk) begin
		if (!aresetn || cmd_reset) begin
			state <= ST_IDLE;
			trig_left <= COUNT_MIN;
			samp_left <= COUNT_MIN;
			first_pass <= 1'b1;
			wait_ms <= '0;
		end else if (cmd_preset || read_go) begin
			state <= ST_TOP;
		end else if (cmd_abort) begin
			state <= cont_on ? ST_TOP : ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_init || cont_on) begin
						state <= ST_TOP;
					end
				end
				ST_TOP: begin
					trig_left <= trig_count;
					samp_left <= samp_count;
					first_pass <= 1'b1;
					state <= ST_SRC;
				end
				ST_SRC: begin
					if (src_ok) begin
						if ((src == SRC_TIM) && !first_pass && (timer_ms > delay_ms)) begin
							wait_ms <= timer_ms;
						end else begin
							wait_ms <= delay_ms;
						end
						state <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (delay_done) begin
						state <= ST_MEAS;
					end
				end
				ST_MEAS: begin
					if (meas_done) begin
						first_pass <= 1'b0;
						if (!last_sample) begin
							samp_left <= samp_left - 16'h0001;
							state <= ST_SRC;
						end else if (!last_trig) begin
							if (!trig_inf) begin
								trig_left <= trig_left - 16'h0001;
							end
							samp_left <= samp_count;
							state <= ST_SRC;
						end else begin
							state <= cont_on ? ST_TOP : ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// delay and timer in ms ticks, cleared outside the delay block
	always_ff @(posedge aclk) begin
		if (!aresetn || (state != ST_DELAY)) begin
			presc <= '0;
			ms_cnt <= '0;
		end else if (presc == 16'(MS_CYCLES - 1)) begin
			presc <= '0;
			ms_cnt <= ms_cnt + 30'h0000001;
		end else begin
			presc <= presc + 16'h0001;
		end
	end

	// ==========================================================
	// measurement handshake and output trigger
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_start <= 1'b0;
			ext_trig_out <= 1'b0;
		end else begin
			meas_start <= (state == ST_DELAY) && delay_done && !seq_kill && !cmd_reset;
			ext_trig_out <= meas_fire && last_sample && !cmd_reset;
		end
	end

	// ==========================================================
	// readings, buffer, result
	logic [15:0] samp_idx;
	assign samp_idx = samp_count - samp_left;

	always_ff @(posedge aclk) begin
		if (meas_fire && (samp_count > COUNT_MIN)) begin
			buf_mem[samp_idx[BUF_AW-1:0]] <= meas_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_reading <= '0;
			have_reading <= 1'b0;
		end else if (meas_fire) begin
			last_reading <= meas_data;
			have_reading <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result <= '0;
			result_valid <= 1'b0;
			read_pending <= 1'b0;
		end else if (read_go) begin
			read_pending <= 1'b1;
			result_valid <= 1'b0;
		end else if (cmd_reset || cmd_preset || cmd_abort) begin
			read_pending <= 1'b0;
		end else if (read_pending && meas_fire && last_sample && last_trig) begin
			result <= meas_data;
			result_valid <= 1'b1;
			read_pending <= 1'b0;
		end else if (cmd_fetch && have_reading) begin
			result <= last_reading;
			result_valid <= 1'b1;
		end
	end

	// ==========================================================
	// AXI4-Lite responses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_view[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_req.bready) begin
			bvalid <= 1'b0;
		end
	end

	logic [32:0] rd_view;
	always_comb rd_view = reg_view(axi_req.araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (axi_req.arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rdata <= rd_view[31:0];
			rresp <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_req.rready) begin
			rvalid <= 1'b0;
		end
	end

	assign axi_rsp = '{
		awready: wr_fire,
		wready: wr_fire,
		bresp: bresp,
		bvalid: bvalid,
		arready: !rvalid,
		rdata: rdata,
		rresp: rresp,
		rvalid: rvalid
	};

endmodule : tmc_trigger_ctrl
